// ==== slave_mode_control.sv ====
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module slave_mode_control #(
    parameter int MS_CYCLES = slave_mode_pkg::CYC_1MS,
    parameter int TENMS_CYCLES = slave_mode_pkg::CYC_10MS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [slave_mode_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [slave_mode_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic requestBusy,
    input wire logic prmReceived,
    input wire logic cfgOkCmd,
    input wire logic telegramValid,
    input wire logic telegramZeroUnits,
    output logic irqOut,
    output logic offline,
    output slave_mode_pkg::slave_state_t slaveState,
    output logic timersStart,
    output logic swapBuffers,
    output logic telegramAccept,
    output logic prmDirect
);
    import slave_mode_pkg::*;

    timer_if tmr();

    logic [IDX_W-1:0] awIdx;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic doWrite;
    logic wrMapped;
    logic [IDX_W-1:0] arIdx;
    logic readTake;
    logic [31:0] readWord;
    logic rdMapped;
    logic [15:0] modeConfig;
    logic [WDV_W-1:0] wdValue;
    logic [CMD_W-1:0] cmdBits;
    logic [CMD_W-1:0] setReq;
    logic [CMD_W-1:0] clrReq;
    logic [CMD_W-1:0] hwClr;
    logic [CMD_W-1:0] next_cmdBits;
    logic [EV_W-1:0] irqStatus;
    logic [EV_W-1:0] irqMask;
    logic [EV_W-1:0] events;
    logic [EV_W-1:0] statusClr;
    logic leaveFire;
    logic goOffline;
    logic swapNow;

    mode_timers #(
        .MS_CYCLES(MS_CYCLES),
        .TENMS_CYCLES(TENMS_CYCLES)
    ) u_timers (
        .clk(clk),
        .rst_n(rst_n),
        .tmr(tmr)
    );

    // Write channels are taken in either order, response after both
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            awIdx <= '0;
        end else if (s_axi_awready && s_axi_awvalid) begin
            s_axi_awready <= 1'b0;
            awIdx <= s_axi_awaddr[ADDR_W-1:2];
        end else if (doWrite) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_wready <= 1'b1;
            wData <= '0;
            wStrb <= '0;
        end else if (s_axi_wready && s_axi_wvalid) begin
            s_axi_wready <= 1'b0;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
        end else if (doWrite) begin
            s_axi_wready <= 1'b1;
        end
    end

    assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wrMapped = awIdx == IDX_CONFIG || awIdx == IDX_CMD_SET ||
        awIdx == IDX_CMD_CLR || awIdx == IDX_IRQ_MASK ||
        awIdx == IDX_WD_VALUE;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Configuration lanes; bits 14 and 15 stay zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            modeConfig <= CONFIG_RESET;
        end else if (doWrite && awIdx == IDX_CONFIG) begin
            for (int lane = 0; lane < 2; lane++) begin
                if (wStrb[lane]) begin
                    modeConfig[lane*8 +: 8] <= wData[lane*8 +: 8] &
                        CFG_WRITABLE[lane*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdValue <= WD_VALUE_RESET;
        end else if (doWrite && awIdx == IDX_WD_VALUE) begin
            for (int lane = 0; lane < 2; lane++) begin
                if (wStrb[lane]) begin
                    wdValue[lane*8 +: 8] <= wData[lane*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqMask <= MASK_RESET;
        end else if (doWrite && awIdx == IDX_IRQ_MASK && wStrb[0]) begin
            irqMask <= wData[EV_W-1:0];
        end
    end

    assign setReq = (doWrite && awIdx == IDX_CMD_SET && wStrb[0]) ?
        wData[CMD_W-1:0] : CMD_RESET;
    assign clrReq = (doWrite && awIdx == IDX_CMD_CLR && wStrb[0]) ?
        wData[CMD_W-1:0] : CMD_RESET;

    assign leaveFire = cmdBits[CMD_LEAVE] && offline;
    assign goOffline = cmdBits[CMD_OFFLINE] && !requestBusy && !offline &&
        !leaveFire;
    assign swapNow = cfgOkCmd && !offline && cmdBits[CMD_SWAP];

    // Self-clearing commands; the swap allow bit is a plain level
    always_comb begin
        hwClr = CMD_RESET;
        hwClr[CMD_LEAVE] = cmdBits[CMD_LEAVE];
        hwClr[CMD_ACK] = cmdBits[CMD_ACK];
        hwClr[CMD_OFFLINE] = leaveFire ||
            (cmdBits[CMD_OFFLINE] && !requestBusy);
        hwClr[CMD_DROP] = cmdBits[CMD_DROP];
        hwClr[CMD_RELOAD] = cmdBits[CMD_RELOAD];
    end

    // zero bits keep their value
    // A host set in the same cycle as a self-clear wins
    assign next_cmdBits = (cmdBits & ~clrReq & ~hwClr) | setReq;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmdBits <= CMD_RESET;
        end else begin
            cmdBits <= next_cmdBits;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            offline <= 1'b1;
            timersStart <= 1'b0;
        end else begin
            timersStart <= leaveFire;
            if (leaveFire) begin
                offline <= 1'b0;
            end else if (goOffline) begin
                offline <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slaveState <= ST_AWAIT_PRM;
        end else if (goOffline || cmdBits[CMD_DROP]) begin
            slaveState <= ST_AWAIT_PRM;
        end else begin
            case (slaveState)
                ST_AWAIT_PRM: begin
                    if (prmReceived && !offline) begin
                        slaveState <= ST_AWAIT_CFG;
                    end
                end
                ST_AWAIT_CFG: begin
                    if (cfgOkCmd && !offline) begin
                        slaveState <= ST_DATA_EX;
                    end
                end
                ST_DATA_EX: begin
                    slaveState <= ST_DATA_EX;
                end
                default: begin
                    slaveState <= ST_AWAIT_PRM;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            swapBuffers <= 1'b0;
            telegramAccept <= 1'b0;
        end else begin
            swapBuffers <= swapNow;
            telegramAccept <= telegramValid && slaveState == ST_DATA_EX &&
                (!telegramZeroUnits || modeConfig[CFG_FAILSAFE]);
        end
    end

    assign prmDirect = modeConfig[CFG_PRM_DIRECT];

    // Watchdog test bit is stored only; the timers ignore it
    assign tmr.ackStart = cmdBits[CMD_ACK];
    assign tmr.ackTimebase = modeConfig[CFG_ACK_TB];
    assign tmr.userTimebase = modeConfig[CFG_USER_TB];
    assign tmr.wdRun = !offline;
    assign tmr.wdReload = cmdBits[CMD_RELOAD];
    assign tmr.wdReloadValue = wdValue;

    always_comb begin
        events = '0;
        events[EV_TICK] = tmr.userTick;
        events[EV_LEFT] = leaveFire;
        events[EV_OFFLINE] = goOffline;
        events[EV_DROP] = cmdBits[CMD_DROP];
        events[EV_WDOG] = tmr.wdExpired;
        events[EV_SWAP] = swapNow;
    end

    assign statusClr = (readTake && arIdx == IDX_IRQ_STATUS) ?
        irqStatus : '0;

    // Read clears what was returned; new events that cycle survive
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqStatus <= '0;
        end else begin
            irqStatus <= (irqStatus & ~statusClr) | events;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqOut <= 1'b0;
        end else begin
            irqOut <= |(irqStatus & irqMask) && !tmr.holdoff &&
                !cmdBits[CMD_ACK];
        end
    end

    assign arIdx = s_axi_araddr[ADDR_W-1:2];
    assign readTake = s_axi_arready && s_axi_arvalid;

    always_comb begin
        readWord = '0;
        rdMapped = 1'b1;
        case (arIdx)
            IDX_CONFIG: readWord[15:0] = modeConfig;
            IDX_CMD_SET: readWord[CMD_W-1:0] = cmdBits;
            IDX_CMD_CLR: readWord[CMD_W-1:0] = cmdBits;
            IDX_STATE: readWord[4:0] = {tmr.holdoff, slaveState, !offline};
            IDX_IRQ_STATUS: readWord[EV_W-1:0] = irqStatus;
            IDX_IRQ_MASK: readWord[EV_W-1:0] = irqMask;
            IDX_WD_VALUE: readWord[WDV_W-1:0] = wdValue;
            default: rdMapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (readTake) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= readWord;
            s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    sequence s_quiet;
        !irqOut [*8];
    endsequence

    property p_ack_quiet;
        @(posedge clk) disable iff (!rst_n)
        cmdBits[CMD_ACK] |=> s_quiet;
    endproperty
    a_ack_quiet: assert property (p_ack_quiet)
        else $error("interrupt active right after ack");

    property p_ack_self;
        @(posedge clk) disable iff (!rst_n)
        cmdBits[CMD_ACK] && !setReq[CMD_ACK] |=> !cmdBits[CMD_ACK];
    endproperty
    a_ack_self: assert property (p_ack_self)
        else $error("ack bit did not self-clear");

    property p_us_window;
        @(posedge clk) disable iff (!rst_n)
        cmdBits[CMD_ACK] && !modeConfig[CFG_ACK_TB] |=>
            ##38 !irqOut;
    endproperty
    a_us_window: assert property (p_us_window)
        else $error("short inactive window too short");

    property p_tick_gap;
        @(posedge clk) disable iff (!rst_n)
        tmr.userTick |=> !tmr.userTick [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap)
        else $error("user ticks too close");

    sequence s_left;
        !offline && timersStart && !cmdBits[CMD_OFFLINE];
    endsequence

    property p_leave;
        @(posedge clk) disable iff (!rst_n)
        leaveFire && !setReq[CMD_OFFLINE] |=> s_left;
    endproperty
    a_leave: assert property (p_leave)
        else $error("leave offline failed");

    property p_go_offline;
        @(posedge clk) disable iff (!rst_n)
        cmdBits[CMD_OFFLINE] && !offline && requestBusy && !leaveFire
            |=> !offline;
    endproperty
    a_go_offline: assert property (p_go_offline)
        else $error("went offline during a request");

    property p_offline_done;
        @(posedge clk) disable iff (!rst_n)
        goOffline && !setReq[CMD_OFFLINE] |=> offline &&
            !cmdBits[CMD_OFFLINE] && slaveState == ST_AWAIT_PRM;
    endproperty
    a_offline_done: assert property (p_offline_done)
        else $error("offline request not completed");

    property p_drop;
        @(posedge clk) disable iff (!rst_n)
        cmdBits[CMD_DROP] && !setReq[CMD_DROP] |=>
            slaveState == ST_AWAIT_PRM && !cmdBits[CMD_DROP];
    endproperty
    a_drop: assert property (p_drop)
        else $error("drop master not honoured");

    property p_swap;
        @(posedge clk) disable iff (!rst_n)
        cfgOkCmd && !offline |=> swapBuffers == $past(cmdBits[CMD_SWAP]);
    endproperty
    a_swap: assert property (p_swap)
        else $error("buffer swap mismatch");

    property p_failsafe;
        @(posedge clk) disable iff (!rst_n)
        telegramValid && telegramZeroUnits && slaveState == ST_DATA_EX
            |=> telegramAccept == $past(modeConfig[CFG_FAILSAFE]);
    endproperty
    a_failsafe: assert property (p_failsafe)
        else $error("zero-unit telegram handling wrong");

    property p_set_swap;
        @(posedge clk) disable iff (!rst_n)
        setReq[CMD_SWAP] |=> cmdBits[CMD_SWAP];
    endproperty
    a_set_swap: assert property (p_set_swap)
        else $error("set address did not set");

    property p_clr_swap;
        @(posedge clk) disable iff (!rst_n)
        clrReq[CMD_SWAP] && !setReq[CMD_SWAP] |=> !cmdBits[CMD_SWAP];
    endproperty
    a_clr_swap: assert property (p_clr_swap)
        else $error("clear address did not clear");

    property p_keep;
        @(posedge clk) disable iff (!rst_n)
        !setReq[CMD_SWAP] && !clrReq[CMD_SWAP] |=> $stable(cmdBits[CMD_SWAP]);
    endproperty
    a_keep: assert property (p_keep)
        else $error("untouched command bit changed");
endmodule : slave_mode_control

// ==== slave_mode_pkg.sv ====
package slave_mode_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int T_1US_NS = 1000;
    localparam int T_1MS_NS = 1000000;
    localparam int T_10MS_NS = 10000000;
    localparam int CYC_1US = (T_1US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_1MS = (T_1MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_10MS = T_10MS_NS / CLK_PERIOD_NS;
    localparam int TIMER_W = 20;
    localparam int ADDR_W = 6;
    localparam int IDX_W = 4;
    localparam int CMD_W = 6;
    localparam int EV_W = 6;
    localparam int WDV_W = 16;

    localparam logic [IDX_W-1:0] IDX_CONFIG = 4'h6;
    localparam logic [IDX_W-1:0] IDX_CMD_SET = 4'h8;
    localparam logic [IDX_W-1:0] IDX_CMD_CLR = 4'h9;
    localparam logic [IDX_W-1:0] IDX_STATE = 4'hA;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 4'hB;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 4'hC;
    localparam logic [IDX_W-1:0] IDX_WD_VALUE = 4'hD;

    localparam int CFG_ACK_TB = 9;
    localparam int CFG_USER_TB = 10;
    localparam int CFG_WATCHDOG_TEST_SELECT = 11;
    localparam int CFG_PRM_DIRECT = 12;
    localparam int CFG_FAILSAFE = 13;
    localparam logic [15:0] CFG_WRITABLE = 16'h3FFF;
    localparam logic [15:0] CONFIG_RESET = 16'h0000;
    localparam logic [WDV_W-1:0] WD_VALUE_RESET = 16'h00FF;

    localparam int CMD_LEAVE = 0;
    localparam int CMD_ACK = 1;
    localparam int CMD_OFFLINE = 2;
    localparam int CMD_DROP = 3;
    localparam int CMD_SWAP = 4;
    localparam int CMD_RELOAD = 5;
    localparam logic [CMD_W-1:0] CMD_RESET = 6'h00;

    localparam int EV_TICK = 0;
    localparam int EV_LEFT = 1;
    localparam int EV_OFFLINE = 2;
    localparam int EV_DROP = 3;
    localparam int EV_WDOG = 4;
    localparam int EV_SWAP = 5;
    localparam logic [EV_W-1:0] MASK_RESET = 6'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_AWAIT_PRM = 3'h1,
        ST_AWAIT_CFG = 3'h2,
        ST_DATA_EX = 3'h4
    } slave_state_t;
endpackage : slave_mode_pkg

// ==== timer_if.sv ====
`timescale 1ns/10ps
interface timer_if;
    logic ackStart;
    logic ackTimebase;
    logic userTimebase;
    logic wdRun;
    logic wdReload;
    logic [15:0] wdReloadValue;
    logic holdoff;
    logic userTick;
    logic wdExpired;
    modport ctrl(output ackStart, ackTimebase, userTimebase, wdRun, wdReload,
        wdReloadValue, input holdoff, userTick, wdExpired);
    modport timers(input ackStart, ackTimebase, userTimebase, wdRun, wdReload,
        wdReloadValue, output holdoff, userTick, wdExpired);
endinterface : timer_if

// ==== mode_timers.sv ====
`timescale 1ns/10ps
module mode_timers #(
    parameter int US_CYCLES = slave_mode_pkg::CYC_1US,
    parameter int MS_CYCLES = slave_mode_pkg::CYC_1MS,
    parameter int TENMS_CYCLES = slave_mode_pkg::CYC_10MS
) (
    input wire logic clk,
    input wire logic rst_n,
    timer_if.timers tmr
);
    import slave_mode_pkg::*;

    logic [TIMER_W-1:0] holdCnt;
    logic [TIMER_W-1:0] tickCnt;
    logic [TIMER_W-1:0] msCnt;
    logic [15:0] wdCnt;
    logic msTick;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            holdCnt <= '0;
            tmr.holdoff <= 1'b0;
        end else if (tmr.ackStart) begin
            holdCnt <= tmr.ackTimebase ? TIMER_W'(MS_CYCLES - 1)
                                       : TIMER_W'(US_CYCLES - 1);
            tmr.holdoff <= 1'b1;
        end else if (holdCnt != '0) begin
            holdCnt <= holdCnt - 1'b1;
        end else begin
            tmr.holdoff <= 1'b0;
        end
    end

    // user tick period
    // New timebase takes effect at the next period boundary
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tickCnt <= '0;
            tmr.userTick <= 1'b0;
        end else if (tickCnt == '0) begin
            tickCnt <= tmr.userTimebase ? TIMER_W'(TENMS_CYCLES - 1)
                                        : TIMER_W'(MS_CYCLES - 1);
            tmr.userTick <= 1'b1;
        end else begin
            tickCnt <= tickCnt - 1'b1;
            tmr.userTick <= 1'b0;
        end
    end

    // Watchdog counts in milliseconds
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msCnt <= '0;
            msTick <= 1'b0;
        end else if (msCnt == '0) begin
            msCnt <= TIMER_W'(MS_CYCLES - 1);
            msTick <= 1'b1;
        end else begin
            msCnt <= msCnt - 1'b1;
            msTick <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdCnt <= '0;
            tmr.wdExpired <= 1'b0;
        end else if (tmr.wdReload || !tmr.wdRun) begin
            wdCnt <= tmr.wdReloadValue;
            tmr.wdExpired <= 1'b0;
        end else begin
            if (msTick && wdCnt != 16'h0000) begin
                wdCnt <= wdCnt - 1'b1;
            end
            tmr.wdExpired <= msTick && wdCnt == 16'h0001;
        end
    end

    property p_hold_len;
        @(posedge clk) disable iff (!rst_n)
        tmr.ackStart |=> tmr.holdoff [*8];
    endproperty
    a_hold_len: assert property (p_hold_len)
        else $error("holdoff ended too early");

    property p_reload_value;
        @(posedge clk) disable iff (!rst_n)
        tmr.wdReload && tmr.wdRun |=> wdCnt == $past(tmr.wdReloadValue);
    endproperty
    a_reload_value: assert property (p_reload_value)
        else $error("watchdog not reloaded");
endmodule : mode_timers

// ==== host_model.sv ====
`timescale 1ns/10ps
module host_model import slave_mode_pkg::*; (
    input wire logic clk,
    output logic [ADDR_W-1:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    task automatic write(input logic [ADDR_W-1:0] a, input logic [31:0] d,
        output logic [1:0] r, output bit hung);
        int i;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (i = 0; i < 1000; i++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        // A hang is reported to the bench, which ends the run
        hung = (i == 1000);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        // Released lines must not keep showing the old value
        s_axi_awaddr <= ~a;
        s_axi_wdata <= ~d;
    endtask : write
    task automatic read(input logic [ADDR_W-1:0] a, output logic [31:0] d,
        output logic [1:0] r, output bit hung);
        int i;
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (i = 0; i < 1000; i++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        hung = (i == 1000);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        s_axi_araddr <= ~a;
    endtask : read
endmodule : host_model

// ==== tb_slave_mode_control.sv ====
`timescale 1ns/10ps
module tb_slave_mode_control;
    import slave_mode_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [3:0] s_axi_wstrb = 4'h3;
    logic requestBusy = 1'b0, prmReceived = 1'b0, cfgOkCmd = 1'b0;
    logic telegramValid = 1'b0, telegramZeroUnits = 1'b1;
    logic irqOut, offline, timersStart, swapBuffers, telegramAccept;
    logic prmDirect;
    slave_state_t slaveState;
    bit hung;
    int errors = 0;
    int check_count = 0;
    always #12.5 clk = ~clk;
    // Short counts keep the run brief
    slave_mode_control #(.MS_CYCLES(100), .TENMS_CYCLES(300)) DUT (.*);
    host_model host (.*);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run(input bit hung);
        if (hung) errors++;
        if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask : wt
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        host.write(a, v, r, hung);
        if (hung) complete_run(1'b1);
        check(r, RESP_OKAY);
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [31:0] m,
        input logic [31:0] e);
        host.read(a, d, r, hung);
        if (hung) complete_run(1'b1);
        check(d & m, e);
    endtask : rd
    task automatic ev3(input logic [2:0] v);
        @(posedge clk);
        {prmReceived, cfgOkCmd, telegramValid} <= v;
        @(posedge clk);
        {prmReceived, cfgOkCmd, telegramValid} <= 3'h0;
        @(negedge clk);
    endtask : ev3
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        wt(1);
        check(offline, 1'h1);
        rd(6'h18, 32'hFFFF, CONFIG_RESET);
        rd(6'h34, 32'hFFFF, WD_VALUE_RESET);
        // Written while offline, watchdog test bit kept zero
        wr(6'h18, 32'h3000);
        rd(6'h18, 32'hFFFF, 32'h3000);
        check(prmDirect, 1'h1);
        wr(6'h30, 32'h02);
        wr(6'h20, 32'h01);
        wt(1);
        check(timersStart, 1'h1);
        wt(2);
        check(offline, 1'h0);
        check(irqOut, 1'h1);
        wr(6'h20, 32'h02);
        wt(3);
        check(irqOut, 1'h0);
        rd(6'h20, 32'h02, 32'h0);
        wt(10);
        check(irqOut, 1'h0);
        wt(50);
        check(irqOut, 1'h1);
        rd(6'h2C, 32'h02, 32'h02);
        wt(2);
        check(irqOut, 1'h0);
        // A full user tick period must raise the tick status bit
        wt(110);
        rd(6'h2C, 32'h01, 32'h01);
        ev3(3'h4);
        wr(6'h20, 32'h10);
        ev3(3'h2);
        check(swapBuffers, 1'h1);
        wr(6'h20, 32'h00);
        rd(6'h20, 32'h10, 32'h10);
        ev3(3'h1);
        check(telegramAccept, 1'h1);
        wr(6'h24, 32'h00);
        rd(6'h24, 32'h10, 32'h10);
        wr(6'h24, 32'h10);
        rd(6'h24, 32'h10, 32'h0);
        ev3(3'h2);
        check(swapBuffers, 1'h0);
        wr(6'h20, 32'h08);
        wt(3);
        check(slaveState, ST_AWAIT_PRM);
        ev3(3'h1);
        check(telegramAccept, 1'h0);
        rd(6'h20, 32'h08, 32'h0);
        wr(6'h20, 32'h20);
        rd(6'h20, 32'h20, 32'h0);
        // Offline entry must wait for the running request
        requestBusy <= 1'b1;
        wr(6'h20, 32'h04);
        wt(5);
        check(offline, 1'h0);
        @(posedge clk);
        requestBusy <= 1'b0;
        wt(4);
        check(offline, 1'h1);
        rd(6'h20, 32'h04, 32'h0);
        host.read(6'h3C, d, r, hung);
        if (hung) complete_run(1'b1);
        check(r, RESP_SLVERR);
        complete_run(1'b0);
    end
endmodule : tb_slave_mode_control
